/* File: smbm_ctrl.sv */
// Packet buffer, pointers, interrupt flags and mode control of the spread modem.
// Assumes an APB master on ref_clk and a baseband whose strobes and link clock
// arrive from another domain and are sampled here.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module smbm_ctrl #(
   parameter int BUF_DEPTH = 256
) (
   // Clock, reset and enable.
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Baseband link inputs.
   input wire logic link_clk,
   input wire logic link_rx_valid,
   input wire logic link_rx_first,
   input wire logic [7:0] link_rx_data,
   input wire logic link_rx_end,
   input wire logic link_crc_err,
   input wire logic link_hdr_valid,
   input wire logic [7:0] link_hdr_len,
   input wire logic link_tx_req,
   input wire logic link_tx_done,
   input wire logic link_cad_done,
   input wire logic link_cad_det,
   input wire logic link_rx_timeout,
   // Baseband transmit data.
   output logic [7:0] tx_data,
   output logic tx_last,
   // Block power controls, modem select and mode code.
   output logic baseband_on,
   output logic tx_synth_on,
   output logic rx_synth_on,
   output logic rf_tx_on,
   output logic rf_rx_on,
   output logic spread_modem_select,
   output logic [2:0] mode_code
);

   typedef struct packed {
      smbm_pkg::smbm_link_t s1;
      smbm_pkg::smbm_link_t s2;
      logic lclk_d;
      logic [255:0][7:0] mem;
      logic [7:0] buffer_access_pointer;
      logic [7:0] tx_region_start;
      logic [7:0] rx_region_start;
      logic [7:0] last_packet_start;
      logic [7:0] rx_byte_count;
      logic [7:0] tx_byte_count;
      logic [7:0] irq_disable_bits;
      logic [7:0] irq_pending_bits;
      logic sel;
      smbm_pkg::smbm_mode_t mode;
      logic [7:0] rx_wr;
      logic [7:0] tx_rd;
      logic [7:0] tx_left;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [7:0] tx_data;
      logic tx_last;
      logic [4:0] pwr;
   } smbm_state_t;

   localparam int REG_NONE = 15;

   smbm_state_t st_reg;
   smbm_state_t st_next;
   smbm_pkg::smbm_link_t link_in;
   smbm_pkg::smbm_link_t lk;
   logic rise;
   logic buf_ok;
   logic in_rx;
   logic setup;
   logic done;
   logic [3:0] sel_idx;
   logic [7:0] rd_val;
   logic [7:0] irq_set;
   logic [7:0] irq_clr;

   // Refuses a depth that the 8-bit pointers cannot serve.
   if (BUF_DEPTH != 256) begin : g_depth_check
      $error("BUF_DEPTH must be 256 for an 8-bit pointer");
   end

   // Maps a byte address to a register index.
   function automatic logic [3:0] smbm_dec(input logic [7:0] a);
      case (a)
         smbm_pkg::OFS_DATA_PORT: smbm_dec = 4'h0;
         smbm_pkg::OFS_ACCESS_PTR: smbm_dec = 4'h1;
         smbm_pkg::OFS_TX_START: smbm_dec = 4'h2;
         smbm_pkg::OFS_RX_START: smbm_dec = 4'h3;
         smbm_pkg::OFS_LAST_START: smbm_dec = 4'h4;
         smbm_pkg::OFS_RX_COUNT: smbm_dec = 4'h5;
         smbm_pkg::OFS_TX_COUNT: smbm_dec = 4'h6;
         smbm_pkg::OFS_IRQ_DISABLE: smbm_dec = 4'h7;
         smbm_pkg::OFS_IRQ_PENDING: smbm_dec = 4'h8;
         smbm_pkg::OFS_OP_MODE: smbm_dec = 4'h9;
         default: smbm_dec = 4'(REG_NONE);
      endcase
   endfunction

   // True for both receive modes.
   function automatic logic smbm_is_rx(input smbm_pkg::smbm_mode_t m);
      smbm_is_rx = (m == smbm_pkg::MODE_RX_REPEAT)
         || (m == smbm_pkg::MODE_RX_ONE_SHOT);
   endfunction

   // Advances a buffer pointer, wrapping from the top location to zero.
   function automatic logic [7:0] smbm_inc(input logic [7:0] p);
      smbm_inc = p + 8'h01;
   endfunction

   // Gathers the link pins into one word for the two-stage sampler.
   assign link_in = '{
      clk: link_clk,
      rx_valid: link_rx_valid,
      rx_first: link_rx_first,
      rx_data: link_rx_data,
      rx_end: link_rx_end,
      crc_err: link_crc_err,
      hdr_valid: link_hdr_valid,
      hdr_len: link_hdr_len,
      tx_req: link_tx_req,
      tx_done: link_tx_done,
      cad_done: link_cad_done,
      cad_det: link_cad_det,
      rx_timeout: link_rx_timeout
   };

   always_comb begin
      st_next = st_reg;
      lk = st_reg.s2;
      rise = 1'b0;
      buf_ok = 1'b0;
      in_rx = 1'b0;
      setup = 1'b0;
      done = 1'b0;
      sel_idx = 4'h0;
      rd_val = 8'h00;
      irq_set = 8'h00;
      irq_clr = 8'h00;

      // Two-stage sampling of the link, edge found on the second stage.
      st_next.s1 = link_in;
      st_next.s2 = st_reg.s1;
      st_next.lclk_d = st_reg.s2.clk;
      rise = st_reg.s2.clk & ~st_reg.lclk_d;

      buf_ok = st_reg.sel && (st_reg.mode != smbm_pkg::MODE_SLEEP);
      in_rx = smbm_is_rx(st_reg.mode);

      setup = psel & ~penable;
      done = psel & penable & st_reg.pready;
      sel_idx = smbm_dec(paddr);

      case (sel_idx)
         4'h0: rd_val = buf_ok ? st_reg.mem[st_reg.buffer_access_pointer] : 8'h00;
         4'h1: rd_val = st_reg.buffer_access_pointer;
         4'h2: rd_val = st_reg.tx_region_start;
         4'h3: rd_val = st_reg.rx_region_start;
         4'h4: rd_val = st_reg.last_packet_start;
         4'h5: rd_val = st_reg.rx_byte_count;
         4'h6: rd_val = st_reg.tx_byte_count;
         4'h7: rd_val = st_reg.irq_disable_bits;
         4'h8: rd_val = st_reg.irq_pending_bits;
         4'h9: rd_val = {st_reg.sel, 4'h0, 3'(st_reg.mode)};
         default: rd_val = 8'h00;
      endcase

      st_next.pready = setup;
      st_next.pslverr = setup && (sel_idx == 4'(REG_NONE));
      if (setup && !pwrite) begin
         st_next.prdata = {24'h000000, rd_val};
      end else begin
         st_next.prdata = 32'h00000000;
      end

      if (done && pwrite) begin
         case (sel_idx)
            4'h0: begin
               if (buf_ok) begin
                  st_next.mem[st_reg.buffer_access_pointer] = pwdata[7:0];
                  st_next.buffer_access_pointer = smbm_inc(st_reg.buffer_access_pointer);
               end
            end
            4'h1: st_next.buffer_access_pointer = pwdata[7:0];
            4'h2: st_next.tx_region_start = pwdata[7:0];
            4'h3: st_next.rx_region_start = pwdata[7:0];
            4'h6: st_next.tx_byte_count = pwdata[7:0];
            4'h7: st_next.irq_disable_bits = pwdata[7:0];
            4'h8: irq_clr = pwdata[7:0];
            4'h9: begin
               if (st_reg.mode == smbm_pkg::MODE_SLEEP) begin
                  st_next.sel = pwdata[smbm_pkg::MODE_SELECT_BIT];
               end
               st_next.mode = smbm_pkg::smbm_mode_t'(pwdata[smbm_pkg::MODE_LSB +: 3]);
            end
            default: st_next.pslverr = 1'b0;
         endcase
      end

      if (done && !pwrite && sel_idx == 4'h0 && buf_ok) begin
         st_next.buffer_access_pointer = smbm_inc(st_reg.buffer_access_pointer);
      end

      if (rise) begin
         if (in_rx && lk.rx_valid) begin
            if (lk.rx_first) begin
               st_next.last_packet_start = st_reg.rx_wr;
            end
            st_next.mem[st_reg.rx_wr] = lk.rx_data;
            st_next.rx_wr = smbm_inc(st_reg.rx_wr);
         end
         if (in_rx && lk.hdr_valid) begin
            st_next.rx_byte_count = lk.hdr_len;
            irq_set[smbm_pkg::IRQ_VALID_HDR] = 1'b1;
         end
         if (in_rx && lk.rx_end) begin
            irq_set[smbm_pkg::IRQ_RX_DONE] = 1'b1;
            irq_set[smbm_pkg::IRQ_CRC_ERROR] = lk.crc_err;
            if (st_reg.mode == smbm_pkg::MODE_RX_ONE_SHOT && !lk.crc_err) begin
               st_next.mode = smbm_pkg::MODE_STANDBY;
            end
         end
         if (st_reg.mode == smbm_pkg::MODE_RX_ONE_SHOT && lk.rx_timeout) begin
            irq_set[smbm_pkg::IRQ_RX_TIMEOUT] = 1'b1;
            st_next.mode = smbm_pkg::MODE_STANDBY;
         end
         if (st_reg.mode == smbm_pkg::MODE_TX) begin
            if (lk.tx_req) begin
               st_next.tx_data = st_reg.mem[st_reg.tx_rd];
               st_next.tx_last = (st_reg.tx_left <= 8'h01);
               st_next.tx_rd = smbm_inc(st_reg.tx_rd);
               if (st_reg.tx_left != 8'h00) begin
                  st_next.tx_left = st_reg.tx_left - 8'h01;
               end
            end
            if (lk.tx_done) begin
               irq_set[smbm_pkg::IRQ_TX_DONE] = 1'b1;
               st_next.mode = smbm_pkg::MODE_STANDBY;
            end
         end
         if (st_reg.mode == smbm_pkg::MODE_CHANNEL_CHECK && lk.cad_done) begin
            irq_set[smbm_pkg::IRQ_CAD_DONE] = 1'b1;
            irq_set[smbm_pkg::IRQ_CAD_DETECT] = lk.cad_det;
            st_next.mode = smbm_pkg::MODE_STANDBY;
         end
      end

      irq_set = irq_set & ~st_reg.irq_disable_bits;
      st_next.irq_pending_bits = (st_reg.irq_pending_bits & ~irq_clr) | irq_set;

      if (st_next.mode != st_reg.mode) begin
         case (st_next.mode)
            smbm_pkg::MODE_SLEEP: begin
               st_next.mem = '0;
            end
            smbm_pkg::MODE_RX_REPEAT, smbm_pkg::MODE_RX_ONE_SHOT: begin
               st_next.mem = '0;
               st_next.rx_wr = st_reg.rx_region_start;
            end
            smbm_pkg::MODE_TX: begin
               st_next.tx_rd = st_reg.tx_region_start;
               st_next.tx_left = st_reg.tx_byte_count;
               st_next.tx_last = 1'b0;
            end
            default: st_next.tx_last = st_reg.tx_last;
         endcase
      end

      // synth modes lock synthesiser, RF off.
      case (st_next.mode)
         smbm_pkg::MODE_SLEEP: st_next.pwr = 5'h00;
         smbm_pkg::MODE_STANDBY: st_next.pwr = 5'h01;
         smbm_pkg::MODE_TX_SYNTH: st_next.pwr = 5'h03;
         smbm_pkg::MODE_TX: st_next.pwr = 5'h0b;
         smbm_pkg::MODE_RX_SYNTH: st_next.pwr = 5'h05;
         default: st_next.pwr = 5'h15;
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg <= '0;
         st_reg.tx_region_start <= smbm_pkg::RST_TX_START;
         st_reg.rx_region_start <= smbm_pkg::RST_RX_START;
         st_reg.tx_byte_count <= smbm_pkg::RST_TX_COUNT;
         st_reg.irq_disable_bits <= smbm_pkg::RST_IRQ_DISABLE;
         st_reg.mode <= smbm_pkg::MODE_SLEEP;
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end

   assign prdata = st_reg.prdata;
   assign pready = st_reg.pready;
   assign pslverr = st_reg.pslverr;
   assign tx_data = st_reg.tx_data;
   assign tx_last = st_reg.tx_last;
   assign baseband_on = st_reg.pwr[0];
   assign tx_synth_on = st_reg.pwr[1];
   assign rx_synth_on = st_reg.pwr[2];
   assign rf_tx_on = st_reg.pwr[3];
   assign rf_rx_on = st_reg.pwr[4];
   assign spread_modem_select = st_reg.sel;
   assign mode_code = 3'(st_reg.mode);

endmodule

`default_nettype wire

/* File: smbm_ctrl_bench.sv */
// Self-checking bench for smbm_ctrl over APB with a baseband stand-in.
// Assumes the checker is bound in and the link model sits on the far side.
`timescale 1ns/100ps
`default_nettype none
module smbm_ctrl_bench;
   logic ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, tx_last;
   logic link_clk, bb, ts, rs, rt, rr, sel, e;
   logic [7:0] paddr, tx_data, ld;
   logic [31:0] pwdata, prdata, r;
   logic [9:0] fl;
   logic [2:0] mode_code;
   logic [7:0] b[4];
   int err_count, tests_run;
   int q[$];
   smbm_ctrl smbm_ctrl_i (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_clk(link_clk),
      .link_rx_valid(fl[0]), .link_rx_first(fl[1]), .link_rx_data(ld),
      .link_rx_end(fl[2]), .link_crc_err(fl[3]), .link_hdr_valid(fl[4]),
      .link_hdr_len(ld), .link_tx_req(fl[5]), .link_tx_done(fl[6]),
      .link_cad_done(fl[7]), .link_cad_det(fl[8]), .link_rx_timeout(fl[9]),
      .tx_data(tx_data), .tx_last(tx_last), .baseband_on(bb), .tx_synth_on(ts),
      .rx_synth_on(rs), .rf_tx_on(rt), .rf_rx_on(rr), .spread_modem_select(sel),
      .mode_code(mode_code));
   smbm_link_model smbm_link_model_i (.link_clk(link_clk), .fl(fl), .ld(ld));
   always #25 ref_clk = ~ref_clk;
   task automatic test_done();
      $display("Checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic cmp(string nm, logic [31:0] x, logic [31:0] g);
      tests_run++;
      if (g !== x) begin
         $display("ERROR %s expected %h seen %h", nm, x, g);
         err_count++;
      end
   endtask
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) err_count++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge ref_clk);
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] x, string nm);
      apb(1'b0, a, 32'h0);
      cmp(nm, {24'h0, x}, r);
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask
   initial begin
      #3000000;
      err_count++;
      test_done();
   end
   initial begin
      ref_clk = 0; reset_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      err_count = 0; tests_run = 0;
      void'($urandom(46));
      foreach (b[i]) b[i] = 8'($urandom);
      repeat (6) @(posedge ref_clk);
      reset_n <= 1'b1;
      rd(smbm_pkg::OFS_TX_START, 8'h80, "tx_start");
      rd(smbm_pkg::OFS_RX_START, 8'h00, "rx_start");
      rd(smbm_pkg::OFS_IRQ_DISABLE, 8'h00, "mask");
      apb(1'b0, 8'h28, 32'h0);
      cmp("slverr", 32'h1, {31'h0, e});
      wr(smbm_pkg::OFS_DATA_PORT, 8'h11);
      rd(smbm_pkg::OFS_DATA_PORT, 8'h00, "sleep data");
      rd(smbm_pkg::OFS_ACCESS_PTR, 8'h00, "sleep ptr");
      wr(smbm_pkg::OFS_OP_MODE, 8'h80);
      wr(smbm_pkg::OFS_OP_MODE, 8'h81);
      wr(smbm_pkg::OFS_OP_MODE, 8'h01);
      rd(smbm_pkg::OFS_OP_MODE, 8'h81, "op mode");
      $display("Test reset and access done");
      wr(smbm_pkg::OFS_ACCESS_PTR, 8'hfe);
      foreach (b[i]) wr(smbm_pkg::OFS_DATA_PORT, b[i]);
      rd(smbm_pkg::OFS_ACCESS_PTR, 8'h02, "ptr wrap");
      for (int m = 2; m < 5; m += 2) begin
         wr(smbm_pkg::OFS_OP_MODE, 8'(8'h80 | m));
         cmp("mode", 32'(m), {29'h0, mode_code});
      end
      wr(smbm_pkg::OFS_ACCESS_PTR, 8'hfe);
      foreach (b[i]) rd(smbm_pkg::OFS_DATA_PORT, b[i], "buffer");
      $display("Test buffer done");
      wr(smbm_pkg::OFS_OP_MODE, 8'h81);
      wr(smbm_pkg::OFS_RX_START, 8'hfe);
      wr(smbm_pkg::OFS_OP_MODE, 8'h85);
      wr(smbm_pkg::OFS_ACCESS_PTR, 8'hfe);
      rd(smbm_pkg::OFS_DATA_PORT, 8'h00, "rx clear");
      for (int i = 1; i < 4; i++) begin
         smbm_link_model_i.ev((i == 1) ? 10'h003 : 10'h001, b[i]);
         q.push_back(int'(b[i]));
      end
      smbm_link_model_i.ev(10'h010, 8'h03);
      smbm_link_model_i.ev(10'h00c, 8'h00);
      rd(smbm_pkg::OFS_LAST_START, 8'hfe, "last start");
      rd(smbm_pkg::OFS_RX_COUNT, 8'h03, "rx count");
      wr(smbm_pkg::OFS_ACCESS_PTR, 8'hfe);
      while (q.size() > 0) begin
         rd(smbm_pkg::OFS_DATA_PORT, 8'(q.pop_front()), "rx byte");
      end
      wr(smbm_pkg::OFS_IRQ_PENDING, 8'h00);
      rd(smbm_pkg::OFS_IRQ_PENDING, 8'h70, "pending");
      wr(smbm_pkg::OFS_IRQ_PENDING, 8'h70);
      rd(smbm_pkg::OFS_IRQ_PENDING, 8'h00, "cleared");
      cmp("repeat mode", 32'h5, {29'h0, mode_code});
      wr(smbm_pkg::OFS_OP_MODE, 8'h81);
      wr(smbm_pkg::OFS_IRQ_DISABLE, 8'h40);
      wr(smbm_pkg::OFS_OP_MODE, 8'h86);
      smbm_link_model_i.ev(10'h004, 8'h00);
      cmp("one shot", 32'h1, {29'h0, mode_code});
      rd(smbm_pkg::OFS_IRQ_PENDING, 8'h00, "masked");
      $display("Test receive done");
      wr(smbm_pkg::OFS_IRQ_DISABLE, 8'h00);
      wr(smbm_pkg::OFS_ACCESS_PTR, 8'h80);
      for (int i = 0; i < 2; i++) begin
         wr(smbm_pkg::OFS_DATA_PORT, b[i]);
         q.push_back(int'(b[i]));
      end
      wr(smbm_pkg::OFS_TX_COUNT, 8'h02);
      wr(smbm_pkg::OFS_OP_MODE, 8'h83);
      for (int i = 0; i < 2; i++) begin
         smbm_link_model_i.ev(10'h020, 8'h00);
         cmp("tx data", 32'(q.pop_front()), {24'h0, tx_data});
         cmp("tx last", 32'(i), {31'h0, tx_last});
      end
      smbm_link_model_i.ev(10'h040, 8'h00);
      cmp("tx end", 32'h1, {29'h0, mode_code});
      rd(smbm_pkg::OFS_IRQ_PENDING, 8'h08, "tx done");
      wr(smbm_pkg::OFS_IRQ_PENDING, 8'h08);
      wr(smbm_pkg::OFS_OP_MODE, 8'h87);
      smbm_link_model_i.ev(10'h180, 8'h00);
      rd(smbm_pkg::OFS_IRQ_PENDING, 8'h05, "channel");
      wr(smbm_pkg::OFS_OP_MODE, 8'h86);
      smbm_link_model_i.ev(10'h200, 8'h00);
      rd(smbm_pkg::OFS_IRQ_PENDING, 8'h85, "timeout");
      $display("Test transmit and events done");
      wr(smbm_pkg::OFS_ACCESS_PTR, 8'h80);
      wr(smbm_pkg::OFS_DATA_PORT, 8'(b[2] | 8'h01));
      wr(smbm_pkg::OFS_OP_MODE, 8'h80);
      rd(smbm_pkg::OFS_TX_COUNT, 8'h02, "sleep read");
      wr(smbm_pkg::OFS_OP_MODE, 8'h00);
      cmp("select", 32'h0, {31'h0, sel});
      rd(smbm_pkg::OFS_TX_COUNT, 8'h02, "other modem");
      wr(smbm_pkg::OFS_OP_MODE, 8'h81);
      wr(smbm_pkg::OFS_ACCESS_PTR, 8'h80);
      rd(smbm_pkg::OFS_DATA_PORT, 8'h00, "sleep clear");
      $display("Test sleep done");
      test_done();
   end
endmodule
`default_nettype wire

/* File: smbm_ctrl_props.sv */
// Checker for the APB answer, power levels and modem select of smbm_ctrl.
// Assumes it is bound to every smbm_ctrl instance and that clk_en is held high.
`timescale 1ns/100ps
`default_nettype none
module smbm_ctrl_props #(
   parameter int BUF_DEPTH = 256
) (
   // Clock, reset and enable.
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // APB.
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Mode and power.
   input wire logic baseband_on,
   input wire logic tx_synth_on,
   input wire logic rx_synth_on,
   input wire logic rf_tx_on,
   input wire logic rf_rx_on,
   input wire logic spread_modem_select,
   input wire logic [2:0] mode_code
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   sequence setup_s;
      psel && !penable && clk_en;
   endsequence
   sequence answer_s;
      pready ##1 !pready;
   endsequence
   ready_after_setup_a: assert property (setup_s |=> answer_s)
      else $error("Access not answered in one cycle.");
   idle_read_zero_a: assert property (!pready |-> prdata == 32'h0)
      else $error("Read data outside answer.");
   upper_bits_zero_a: assert property (prdata[31:8] == 24'h0)
      else $error("Upper read bits set.");
   error_with_ready_a: assert property (pslverr |-> pready && psel && penable)
      else $error("Error outside access.");
   sleep_power_a: assert property (mode_code == 3'h0 |->
      !(baseband_on || tx_synth_on || rx_synth_on || rf_tx_on || rf_rx_on))
      else $error("Block powered in sleep.");
   standby_power_a: assert property (mode_code == 3'h1 |->
      baseband_on && !tx_synth_on && !rx_synth_on && !rf_tx_on && !rf_rx_on)
      else $error("Wrong standby power.");
   synth_rf_off_a: assert property ((mode_code == 3'h2 || mode_code == 3'h4) |->
      !rf_tx_on && !rf_rx_on && tx_synth_on == (mode_code == 3'h2)
      && rx_synth_on == (mode_code == 3'h4))
      else $error("Wrong synthesis power.");
   select_in_sleep_a: assert property (!$stable(spread_modem_select) |->
      $past(mode_code) == 3'h0)
      else $error("Select changed outside sleep.");
endmodule
bind smbm_ctrl smbm_ctrl_props #(.BUF_DEPTH(BUF_DEPTH)) smbm_ctrl_props_i (
   .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .psel(psel),
   .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .baseband_on(baseband_on), .tx_synth_on(tx_synth_on), .rx_synth_on(rx_synth_on),
   .rf_tx_on(rf_tx_on), .rf_rx_on(rf_rx_on), .spread_modem_select(spread_modem_select),
   .mode_code(mode_code));
`default_nettype wire

/* File: smbm_link_model.sv */
// Baseband stand-in driving the link clock, strobes and data.
// Assumes the bench calls ev once per event; the clock rests low between.
`timescale 1ns/100ps
`default_nettype none
module smbm_link_model (
   // Link clock, strobes and data.
   output logic link_clk,
   output logic [9:0] fl,
   output logic [7:0] ld
);
   initial begin
      link_clk = 1'b0;
      fl = 10'h0;
      ld = 8'h5a;
   end
   task automatic ev(input logic [9:0] f, input logic [7:0] d);
      #1;
      fl = f;
      ld = d;
      #199;
      link_clk = 1'b1;
      #200;
      link_clk = 1'b0;
      fl = 10'h0;
      ld = ~d;
   endtask
endmodule
`default_nettype wire

/* File: smbm_pkg.sv */
// Package for the spread modem buffer and mode controller.
// Assumes a single 20 MHz register clock and an APB master with 32-bit data.
package smbm_pkg;

   // Register byte offsets.
   localparam logic [7:0] OFS_DATA_PORT = 8'h00;
   localparam logic [7:0] OFS_ACCESS_PTR = 8'h04;
   localparam logic [7:0] OFS_TX_START = 8'h08;
   localparam logic [7:0] OFS_RX_START = 8'h0c;
   localparam logic [7:0] OFS_LAST_START = 8'h10;
   localparam logic [7:0] OFS_RX_COUNT = 8'h14;
   localparam logic [7:0] OFS_TX_COUNT = 8'h18;
   localparam logic [7:0] OFS_IRQ_DISABLE = 8'h1c;
   localparam logic [7:0] OFS_IRQ_PENDING = 8'h20;
   localparam logic [7:0] OFS_OP_MODE = 8'h24;

   // Reset values.
   localparam logic [7:0] RST_TX_START = 8'h80;
   localparam logic [7:0] RST_RX_START = 8'h00;
   localparam logic [7:0] RST_IRQ_DISABLE = 8'h00;
   localparam logic [7:0] RST_TX_COUNT = 8'h01;

   // Field positions in the operating mode register.
   localparam int MODE_SELECT_BIT = 7;
   localparam int MODE_LSB = 0;

   // Interrupt bit positions.
   localparam int IRQ_CAD_DETECT = 0;
   localparam int IRQ_CAD_DONE = 2;
   localparam int IRQ_TX_DONE = 3;
   localparam int IRQ_VALID_HDR = 4;
   localparam int IRQ_CRC_ERROR = 5;
   localparam int IRQ_RX_DONE = 6;
   localparam int IRQ_RX_TIMEOUT = 7;

   // Operating modes, in register code order.
   typedef enum logic [2:0] {
      MODE_SLEEP,
      MODE_STANDBY,
      MODE_TX_SYNTH,
      MODE_TX,
      MODE_RX_SYNTH,
      MODE_RX_REPEAT,
      MODE_RX_ONE_SHOT,
      MODE_CHANNEL_CHECK
   } smbm_mode_t;

   // Signals from the modem baseband, sampled together.
   typedef struct packed {
      logic clk;
      logic rx_valid;
      logic rx_first;
      logic [7:0] rx_data;
      logic rx_end;
      logic crc_err;
      logic hdr_valid;
      logic [7:0] hdr_len;
      logic tx_req;
      logic tx_done;
      logic cad_done;
      logic cad_det;
      logic rx_timeout;
   } smbm_link_t;

endpackage
